// File: rtl/arzc_pkg.sv
/*
 * Shared constants and types for the autoreclose sequencer with zone coordination.
 * Assumes a single 10 MHz system clock; BRK_SUP_US is in microseconds, the other times are in clock cycles.
 */
package arzc_pkg;
   localparam int unsigned CLK_MHZ        = 10;
   localparam int unsigned SHOT_W         = 3;
   localparam int unsigned TMR_W          = 24;
   localparam int unsigned MAX_SHOTS      = 4;
   // Breaker open supervision time after a trip
   localparam int unsigned BRK_SUP_US     = 200000;
   localparam int unsigned BRK_SUP_CYC    = BRK_SUP_US * CLK_MHZ;
   localparam logic [SHOT_W-1:0] SHOT_RST = 3'h0;
   // Default sequence times in clock cycles; shortened by the bench
   localparam int unsigned FAULT_TM_CYC   = 1000000; // 100 ms fault timer
   localparam int unsigned MANBLK_TM_CYC  = 1000000; // 100 ms manual-close blocking
   localparam int unsigned RECLAIM_TM_CYC = 5000000; // 500 ms reclaim
   localparam int unsigned CLOSE_TM_CYC   = 1000000; // 100 ms close supervision

   typedef enum logic [2:0] {
      ARZC_STANDBY, ARZC_MANBLK, ARZC_READY, ARZC_RUN,
      ARZC_WAIT_OPEN, ARZC_DEAD, ARZC_RECLOSING, ARZC_RECLAIM
   } arzc_state_t;

   // Protection inputs grouped together
   typedef struct packed {
      logic pickup;   // assigned overcurrent pickup
      logic trip;     // assigned initiate trip
   } arzc_prot_t;

   // Result flags
   typedef struct packed {
      logic success;
      logic failed;
      logic lockout;
   } arzc_flags_t;
endpackage : arzc_pkg

// File: rtl/arzc_seq.sv
/*
 * Reclose sequencer with manual-close blocking and zone coordination.
 * Assumes pins are asynchronous (synchronised here) and settings are static.
 */
`timescale 1ns/1ps
module arzc_seq import arzc_pkg::*; #(
   parameter int unsigned        SHOTS        = MAX_SHOTS,
   parameter logic [TMR_W-1:0]   FAULT_CYC    = TMR_W'(FAULT_TM_CYC),
   parameter logic [TMR_W-1:0]   BRK_SUP      = TMR_W'(BRK_SUP_CYC),
   parameter logic [TMR_W-1:0]   MANBLK_CYC   = TMR_W'(MANBLK_TM_CYC),
   parameter logic [TMR_W-1:0]   RECLAIM_CYC  = TMR_W'(RECLAIM_TM_CYC),
   parameter logic [TMR_W-1:0]   CLOSE_SUP    = TMR_W'(CLOSE_TM_CYC)
) (
   input  wire logic                    clk,          // System clock, 10 MHz
   input  wire logic                    rst_n,        // Async reset, active low
   input  wire logic                    enable,       // Reclose function active
   input  wire logic                    zone_coord,   // Zone coordination mode
   input  wire logic                    block_in,     // External blocking (pin)
   input  wire logic                    lockout_rst,  // Lockout reset request (pin)
   input  wire arzc_prot_t              prot_in,      // Pickup and trip (pins)
   input  wire logic                    brk_closed,   // Breaker position (pin)
   input  wire logic [TMR_W-1:0]        dead_cyc [SHOTS], // Dead time per shot
   output arzc_state_t                  state_q,      // Sequencer state
   output logic [SHOT_W-1:0]            shot_q,       // Shot for setting selection
   output logic                         trip_q,       // Open-breaker command
   output logic                         close_q,      // Reclose command pulse
   output arzc_flags_t                  flags_q       // Success, failed, lockout
);
   // Two-stage synchronisers for all pin inputs
   logic [4:0] s1_q, s2_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 5'h00;
         s2_q <= 5'h00;
      end else begin
         s1_q <= {block_in, lockout_rst, prot_in.pickup, prot_in.trip, brk_closed};
         s2_q <= s1_q;
      end
   end
   logic blk, lrst, pick, trp, cls;
   assign {blk, lrst, pick, trp, cls} = s2_q;

   // Previous levels for edge detection on synchronised signals
   logic pick_q, cls_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pick_q <= 1'b0;
         cls_q  <= 1'b0;
      end else begin
         pick_q <= pick;
         cls_q  <= cls;
      end
   end
   wire pick_drop = pick_q & ~pick;
   wire man_close = cls & ~cls_q;

   // One shared timer; only one delay is ever live at a time
   logic             t_load, t_clear, t_run, t_done;
   logic [TMR_W-1:0] t_len;
   arzc_timer #(.W(TMR_W)) u_tmr (
      .clk     (clk),
      .rst_n   (rst_n),
      .load    (t_load),
      .clear   (t_clear),
      .length  (t_len),
      .running (t_run),
      .done    (t_done)
   );

   wire last_shot = (32'(shot_q) >= SHOTS);
   wire [TMR_W-1:0] dead_now = dead_cyc[last_shot ? SHOTS-1 : 32'(shot_q)];

   // Trip is passed straight on in every state, timers untouched
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) trip_q <= 1'b0;
      else        trip_q <= trp;
   end

   // Main sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ARZC_STANDBY;
         shot_q  <= SHOT_RST;
         close_q <= 1'b0;
         flags_q <= '0;
         t_load  <= 1'b0;
         t_clear <= 1'b0;
         t_len   <= '0;
      end else begin
         t_load  <= 1'b0;
         t_clear <= 1'b0;
         close_q <= 1'b0;
         if (!enable || blk) begin
            // Blocking parks the sequence; shot count restarts afterwards
            if (state_q != ARZC_STANDBY && state_q != ARZC_MANBLK) begin
               state_q <= cls ? ARZC_READY : ARZC_STANDBY;
               shot_q  <= SHOT_RST;
               t_clear <= 1'b1;
            end
         end else if (flags_q.lockout) begin
            if (lrst && cls) begin
               flags_q.lockout <= 1'b0;
               state_q         <= ARZC_READY;
               shot_q          <= SHOT_RST;
            end
         end else begin
            case (state_q)
               ARZC_STANDBY: begin
                  if (man_close) begin
                     state_q <= ARZC_MANBLK;
                     t_len   <= MANBLK_CYC;
                     t_load  <= 1'b1;
                  end
               end
               ARZC_MANBLK: begin
                  // Trips do not touch the timer here
                  if (t_done) begin
                     state_q <= cls ? ARZC_READY : ARZC_STANDBY;
                  end
               end
               ARZC_READY: begin
                  if (!cls && !trp) state_q <= ARZC_STANDBY;
                  else if (pick || trp) begin
                     state_q         <= ARZC_RUN;
                     flags_q.success <= 1'b0;
                     flags_q.failed  <= 1'b0;
                     t_len           <= FAULT_CYC;
                     t_load          <= 1'b1;
                  end
               end
               ARZC_RUN: begin
                  if (zone_coord && !trp && pick_drop) begin
                     // Downstream device cleared it; own breaker stays in
                     state_q <= ARZC_DEAD;
                     t_len   <= dead_now;
                     t_load  <= 1'b1;
                  end else if (trp) begin
                     state_q <= ARZC_WAIT_OPEN;
                     t_len   <= BRK_SUP;
                     t_load  <= 1'b1;
                  end else if (t_done) begin
                     flags_q.lockout <= 1'b1;
                     flags_q.failed  <= 1'b1;
                  end
               end
               ARZC_WAIT_OPEN: begin
                  if (!cls) begin
                     state_q <= ARZC_DEAD;
                     t_len   <= dead_now;
                     t_load  <= 1'b1;
                  end else if (t_done) begin
                     flags_q.lockout <= 1'b1;
                     flags_q.failed  <= 1'b1;
                  end
               end
               ARZC_DEAD: begin
                  if (t_done) begin
                     shot_q <= shot_q + SHOT_W'(1);
                     if (zone_coord && cls) begin
                        state_q <= ARZC_RECLAIM;
                        t_len   <= RECLAIM_CYC;
                        t_load  <= 1'b1;
                     end else if (!cls && !pick && !trp) begin
                        close_q <= 1'b1;
                        state_q <= ARZC_RECLOSING;
                        t_len   <= CLOSE_SUP;
                        t_load  <= 1'b1;
                     end else begin
                        flags_q.lockout <= 1'b1;
                        flags_q.failed  <= 1'b1;
                     end
                  end
               end
               ARZC_RECLOSING: begin
                  if (cls) begin
                     state_q <= ARZC_RECLAIM;
                     t_len   <= RECLAIM_CYC;
                     t_load  <= 1'b1;
                  end else if (t_done) begin
                     flags_q.lockout <= 1'b1;
                     flags_q.failed  <= 1'b1;
                  end
               end
               ARZC_RECLAIM: begin
                  if (pick || trp) begin
                     if (last_shot) begin
                        flags_q.lockout <= 1'b1;
                        flags_q.failed  <= 1'b1;
                        t_clear         <= 1'b1;
                     end else begin
                        state_q <= ARZC_RUN;
                        t_len   <= FAULT_CYC;
                        t_load  <= 1'b1;
                     end
                  end else if (t_done) begin
                     state_q         <= ARZC_READY;
                     shot_q          <= SHOT_RST;
                     flags_q.success <= 1'b1;
                  end
               end
               default: state_q <= ARZC_STANDBY;
            endcase
         end
      end
   end

   // Zone mode issues no close after dead time while the breaker is still closed
   a_zone_no_close: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ARZC_DEAD && t_done && zone_coord && cls) |=> !close_q)
      else $error("close issued in zone coordination");

   // Dead expiry advances shot by exactly one
   a_shot_incr: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ARZC_DEAD && t_done && enable && !blk && !flags_q.lockout)
      |=> shot_q == $past(shot_q) + SHOT_W'(1))
      else $error("shot not incremented");

   // Blocking timer expiry with open breaker goes to standby, not lockout
   a_manblk_open: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ARZC_MANBLK && t_done && !cls && enable && !blk && !flags_q.lockout)
      |=> state_q == ARZC_STANDBY && !flags_q.lockout)
      else $error("bad exit from manual close block");

   // Trip follows input within one cycle even while blocking
   a_trip_pass: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ARZC_MANBLK && trp) |=> trip_q)
      else $error("trip suppressed during blocking");

   // Manual close from standby starts blocking
   a_man_block: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ARZC_STANDBY && man_close && enable && !blk && !flags_q.lockout)
      |=> state_q == ARZC_MANBLK ##1 t_run)
      else $error("manual close did not start blocking");

   // Zone dropout starts the dead timer
   a_zone_dead: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ARZC_RUN && zone_coord && !trp && pick_drop && enable && !blk
       && !flags_q.lockout) |=> state_q == ARZC_DEAD ##1 t_run)
      else $error("dead timer not started on dropout");

   // Quiet reclaim expiry reports success
   a_reclaim_ok: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ARZC_RECLAIM && t_done && !pick && !trp && enable && !blk
       && !flags_q.lockout) |=> state_q == ARZC_READY && flags_q.success
       && shot_q == SHOT_RST)
      else $error("reclaim expiry not successful");

   // Fault in reclaim on last shot locks out
   a_final_lock: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ARZC_RECLAIM && pick && last_shot && enable && !blk && !flags_q.lockout)
      |=> flags_q.lockout && flags_q.failed)
      else $error("no lockout after last shot");
endmodule : arzc_seq

// File: rtl/arzc_timer.sv
/*
 * Down-counting one-shot timer used for every sequence delay.
 * Assumes load and the length come from the same clock domain.
 */
`timescale 1ns/1ps
module arzc_timer import arzc_pkg::*; #(
   parameter int unsigned W = TMR_W
) (
   input  wire logic         clk,     // System clock
   input  wire logic         rst_n,   // Async reset, active low
   input  wire logic         load,    // Start pulse
   input  wire logic         clear,   // Abort
   input  wire logic [W-1:0] length,  // Cycles to count
   output logic              running, // Counting
   output logic              done     // One-cycle expiry pulse
);
   logic [W-1:0] cnt_q;

   // Load wins over clear so a restart is never lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q   <= '0;
         running <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            cnt_q   <= (length == '0) ? W'(1) : length;
            running <= 1'b1;
         end else if (clear) begin
            running <= 1'b0;
         end else if (running) begin
            if (cnt_q == W'(1)) begin
               running <= 1'b0;
               done    <= 1'b1;
            end
            cnt_q <= cnt_q - W'(1);
         end
      end
   end
endmodule : arzc_timer

// File: testbench/arzc_brk_model.sv
/*
 * Behavioural circuit breaker that sits across from the reclose sequencer.
 * Assumes commands arrive as registered levels or pulses in the clk domain.
 */
`timescale 1ns/1ps
module arzc_brk_model (
   input  wire logic clk,        // System clock
   input  wire logic rst_n,      // Async reset, active low
   input  wire logic trip_cmd,   // Open command from the sequencer
   input  wire logic close_cmd,  // Reclose pulse from the sequencer
   input  wire logic man_close,  // Operator close request
   input  wire logic man_open,   // Operator open request
   output logic      brk_closed  // Position, 1 = closed
);
   // Opening wins over closing, as a real trip coil overrides a close
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         brk_closed <= 1'b0;
      end else if (trip_cmd || man_open) begin
         brk_closed <= 1'b0;
      end else if (close_cmd || man_close) begin
         brk_closed <= 1'b1;
      end
   end
endmodule : arzc_brk_model

// File: testbench/tb_arzc_seq.sv
/*
 * Self-checking bench for the reclose sequencer with zone coordination.
 * Assumes shortened sequence timers and the breaker model beside the sequencer.
 */
`timescale 1ns/1ps
module tb_arzc_seq import arzc_pkg::*; ();
   localparam int MB = 20;
   localparam int RC = 40;
   logic             clk, rst_n, enable, zone_coord, block_in, lockout_rst;
   logic             man_close, man_open, brk_closed, trip_o, close_o;
   arzc_prot_t       prot_in;
   logic [TMR_W-1:0] dead_cyc [4];
   arzc_state_t      state;
   logic [SHOT_W-1:0] shot;
   arzc_flags_t      flags;
   int               fails, num_checks, closes, seed, n;

   arzc_seq #(.FAULT_CYC(24'h0000c8), .BRK_SUP(24'h000014),
      .MANBLK_CYC(24'h000014), .RECLAIM_CYC(24'h000028), .CLOSE_SUP(24'h000014)) dut (
      .clk(clk), .rst_n(rst_n), .enable(enable), .zone_coord(zone_coord),
      .block_in(block_in), .lockout_rst(lockout_rst), .prot_in(prot_in),
      .brk_closed(brk_closed), .dead_cyc(dead_cyc), .state_q(state), .shot_q(shot),
      .trip_q(trip_o), .close_q(close_o), .flags_q(flags));

   arzc_brk_model brk (.clk(clk), .rst_n(rst_n), .trip_cmd(trip_o), .close_cmd(close_o),
      .man_close(man_close), .man_open(man_open), .brk_closed(brk_closed));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Zone mode must not command a reclose while the breaker stays in, so every pulse is counted
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)                closes <= 0;
      else if (close_o === 1'b1) closes <= closes + 1;
   end

   // Blocking span: length plus expiry pulse plus state update
   function automatic int mb_span(input int len);
      return len + 2;
   endfunction : mb_span

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // Bounded wait for a state; a timeout ends the run
   task automatic wait_st(input arzc_state_t st, input int lim);
      n = 0;
      while (state !== st && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         fails++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, state, st);
         end_of_test();
      end
   endtask : wait_st

   // One virtual shot: pickup held a random while, then dropped
   task automatic zshot(input int k);
      int h;
      h = 5 + ($random(seed) & 7);
      prot_in.pickup = 1'b1;
      wait_st(ARZC_RUN, 10);
      check(shot, k - 1);
      repeat (h) @(negedge clk);
      prot_in.pickup = 1'b0;
      wait_st(ARZC_DEAD, 10);
      wait_st(ARZC_RECLAIM, 40);
      check(shot, k);
   endtask : zshot

   // Main sequence
   initial begin
      seed = 32'ha637;
      {rst_n, block_in, lockout_rst, man_close, man_open} = '0;
      {enable, zone_coord} = 2'b11;
      prot_in = '0;
      fails = 0;
      num_checks = 0;
      for (int i = 0; i < 4; i++) dead_cyc[i] = TMR_W'(5 + ($random(seed) & 15));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      check(state, ARZC_STANDBY);
      check(shot, 0);
      check(flags, 0);
      $display("test reset done");
      man_close = 1'b1;
      @(negedge clk);
      man_close = 1'b0;
      wait_st(ARZC_MANBLK, 10);
      wait_st(ARZC_READY, 2 * MB);
      check(n, mb_span(MB));
      $display("test manual close done");
      for (int k = 1; k <= 4; k++) zshot(k);
      prot_in.pickup = 1'b1;
      repeat (4) @(negedge clk);
      check(flags.lockout, 1);
      check(flags.failed, 1);
      prot_in.pickup = 1'b0;
      lockout_rst = 1'b1;
      wait_st(ARZC_READY, 10);
      lockout_rst = 1'b0;
      $display("test permanent fault done");
      zshot(1);
      wait_st(ARZC_READY, RC + 10);
      check(flags.success, 1);
      check(shot, 0);
      check(closes, 0);
      $display("test transient fault done");
      man_open = 1'b1;
      @(negedge clk);
      man_open = 1'b0;
      wait_st(ARZC_STANDBY, 10);
      man_close = 1'b1;
      @(negedge clk);
      man_close = 1'b0;
      wait_st(ARZC_MANBLK, 10);
      repeat (5) @(negedge clk);
      prot_in.trip = 1'b1;
      repeat (4) @(negedge clk);
      check(trip_o, 1);
      check(brk_closed, 0);
      check(state, ARZC_MANBLK);
      prot_in.trip = 1'b0;
      wait_st(ARZC_STANDBY, 2 * MB);
      check(n + 9, mb_span(MB));
      check(flags.lockout, 0);
      $display("test trip during blocking done");
      // Normal mode: real trip, breaker opens, dead time, one reclose
      zone_coord = 1'b0;
      man_close = 1'b1;
      @(negedge clk);
      man_close = 1'b0;
      wait_st(ARZC_READY, 3 * MB);
      prot_in = 2'b11;
      wait_st(ARZC_WAIT_OPEN, 10);
      prot_in = '0;
      wait_st(ARZC_DEAD, 10);
      wait_st(ARZC_RECLAIM, 40);
      check(shot, 1);
      check(closes, 1);
      wait_st(ARZC_READY, RC + 10);
      check(flags.success, 1);
      check(shot, 0);
      $display("test normal reclose done");
      // Blocking in reclaim parks the sequence without success
      zone_coord = 1'b1;
      zshot(1);
      block_in = 1'b1;
      repeat (4) @(negedge clk);
      check(state, ARZC_READY);
      check(flags.success, 0);
      check(shot, 0);
      // Disabled function must ignore a pickup
      block_in = 1'b0;
      enable = 1'b0;
      prot_in.pickup = 1'b1;
      repeat (6) @(negedge clk);
      check(state, ARZC_READY);
      prot_in.pickup = 1'b0;
      repeat (4) @(negedge clk);
      enable = 1'b1;
      repeat (2) @(negedge clk);
      check(state, ARZC_READY);
      $display("test blocking done");
      end_of_test();
   end
endmodule : tb_arzc_seq
